// [src/iprl_pkg.sv]
// Package of constants and types for the port reset and low-power control block
package iprl_pkg;
	// ----------------------------------------------------------------
	// Drive mode codes
	// ----------------------------------------------------------------
	localparam logic [2:0] DM_HIZ_ANALOG = 3'h0;
	localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
	localparam logic [2:0] DM_PULL_UP = 3'h2;
	localparam logic [2:0] DM_PULL_DOWN = 3'h3;
	localparam logic [2:0] DM_OD_LOW = 3'h4;
	localparam logic [2:0] DM_OD_HIGH = 3'h5;
	localparam logic [2:0] DM_STRONG = 3'h6;
	localparam logic [2:0] DM_PULL_BOTH = 3'h7;

	// ----------------------------------------------------------------
	// Reset configuration codes held in nonvolatile storage
	// ----------------------------------------------------------------
	localparam logic [1:0] RCFG_HIZ = 2'h0;
	localparam logic [1:0] RCFG_PULL_DOWN = 2'h1;
	localparam logic [1:0] RCFG_PULL_UP = 2'h2;

	// ----------------------------------------------------------------
	// Pin interrupt modes
	// ----------------------------------------------------------------
	localparam logic [1:0] IMODE_NONE = 2'h0;
	localparam logic [1:0] IMODE_RISE = 2'h1;
	localparam logic [1:0] IMODE_FALL = 2'h2;
	localparam logic [1:0] IMODE_BOTH = 2'h3;

	// ----------------------------------------------------------------
	// Special pin threshold selections
	// ----------------------------------------------------------------
	localparam logic [1:0] THR_HALF_SUPPLY = 2'h0;
	localparam logic [1:0] THR_FORTY_SUPPLY = 2'h1;
	localparam logic [1:0] THR_HALF_REF = 2'h2;
	localparam logic [1:0] THR_ANALOG_GLOBAL = 2'h3;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [2:0] DM_RESET = 3'h0;
	localparam int NV_LOAD_CYCLES = 2;

	// Configuration of one special pin pair
	typedef struct packed {
		logic [1:0] thr_sel;
		logic hyst_en;
	} iprl_pair_cfg_t;

	// Pin pad controls for one pin
	typedef struct packed {
		logic [2:0] drive_mode;
		logic out_val;
	} iprl_pad_t;
endpackage

// [src/iprl_edge_det.sv]
// Per-pin edge detector for the port interrupt unit
`timescale 1ns/10ps
module iprl_edge_det (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Pin and mode
	input wire logic pin_in,
	input wire logic [1:0] mode,
	// Event pulse
	output logic event_p
);
	logic prev_r;

	// Previous pin level, kept through low power
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_r <= 1'b0;
		end else if (ce) begin
			prev_r <= pin_in;
		end
	end

	// Mode-qualified edge decode
	always_comb begin
		case (mode)
			iprl_pkg::IMODE_RISE: event_p = ce & pin_in & ~prev_r;
			iprl_pkg::IMODE_FALL: event_p = ce & ~pin_in & prev_r;
			iprl_pkg::IMODE_BOTH: event_p = ce & (pin_in ^ prev_r);
			default: event_p = 1'b0;
		endcase
	end
endmodule

// [src/iprl_port.sv]
// Top of the port reset, low-power and special pin control block
`timescale 1ns/10ps
module iprl_port #(
	parameter int NPINS = 8,
	parameter int NPAIRS = 1
) (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Nonvolatile reset configuration
	input wire logic [1:0] nv_reset_cfg,
	// Software configuration
	input wire logic cfg_we,
	input wire logic [NPINS*3-1:0] cfg_drive_mode,
	input wire logic [NPINS-1:0] cfg_out_val,
	input wire logic [NPINS*2-1:0] cfg_int_mode,
	input wire iprl_pkg::iprl_pair_cfg_t [NPAIRS-1:0] cfg_pair,
	input wire logic low_power,
	// Interrupt status handling
	input wire logic [NPINS-1:0] int_clear,
	// Pins and comparator input
	input wire logic [NPINS-1:0] pin_in,
	input wire logic [NPAIRS-1:0] ag_cmp_above,
	// Boundary scan
	input wire logic bs_mode,
	input wire logic bs_shift,
	input wire logic bs_capture,
	input wire logic bs_update,
	input wire logic bs_tdi,
	output logic bs_tdo,
	// Pad controls
	output iprl_pkg::iprl_pad_t [NPINS-1:0] pad,
	output iprl_pkg::iprl_pair_cfg_t [NPAIRS-1:0] pair_ref,
	output logic [NPAIRS-1:0] pair_cmp_out,
	// Status
	output logic [NPINS-1:0] int_status,
	output logic int_req,
	output logic wake_req,
	output logic [1:0] reset_cfg,
	output logic held_in_reset
);
	// ----------------------------------------------------------------
	// Reset sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_HOLD = 3'b001,
		ST_LOAD = 3'b010,
		ST_RUN = 3'b100
	} iprl_state_t;

	iprl_state_t state_r;
	iprl_state_t state_nxt;
	logic [1:0] load_cnt_r;
	logic [1:0] reset_cfg_r;
	iprl_pkg::iprl_pad_t [NPINS-1:0] pad_r;
	iprl_pkg::iprl_pair_cfg_t [NPAIRS-1:0] pair_r;
	logic [NPINS*2-1:0] imode_r;
	logic [NPINS-1:0] status_r;
	logic [NPINS-1:0] event_p;
	logic [NPAIRS-1:0] cmp_r;
	logic [NPINS-1:0] bs_cap_r;
	logic [NPINS-1:0] bs_upd_r;

	// Map a reset configuration code to a drive mode
	function automatic logic [2:0] rcfg_mode(input logic [1:0] code);
		case (code)
			iprl_pkg::RCFG_PULL_DOWN: rcfg_mode = iprl_pkg::DM_PULL_DOWN;
			iprl_pkg::RCFG_PULL_UP: rcfg_mode = iprl_pkg::DM_PULL_UP;
			default: rcfg_mode = iprl_pkg::DM_HIZ_ANALOG;
		endcase
	endfunction

	// Next state of the reset sequencer
	always_comb begin
		case (state_r)
			ST_HOLD: state_nxt = ST_LOAD;
			ST_LOAD: state_nxt = (load_cnt_r == 2'(iprl_pkg::NV_LOAD_CYCLES - 1)) ? ST_RUN : ST_LOAD;
			ST_RUN: state_nxt = ST_RUN;
			default: state_nxt = ST_HOLD;
		endcase
	end

	// Sequencer state register
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ST_HOLD;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	// Load cycle counter
	always_ff @(posedge clk) begin
		if (rst) begin
			load_cnt_r <= 2'h0;
		end else if (ce && state_r == ST_LOAD) begin
			load_cnt_r <= load_cnt_r + 2'h1;
		end
	end

	// Copy of nonvolatile reset configuration at release
	always_ff @(posedge clk) begin
		if (rst) begin
			reset_cfg_r <= iprl_pkg::RCFG_HIZ;
		end else if (ce && state_r == ST_LOAD) begin
			reset_cfg_r <= nv_reset_cfg;
		end
	end

	// ----------------------------------------------------------------
	// Pin configuration
	// ----------------------------------------------------------------
	// Drive state: held in reset, reset config at release, then software
	always_ff @(posedge clk) begin
		if (rst) begin
			pad_r <= '0;
		end else if (ce) begin
			for (int i = 0; i < NPINS; i++) begin
				if (state_r == ST_LOAD && state_nxt == ST_RUN) begin
					pad_r[i].drive_mode <= rcfg_mode(reset_cfg_r);
					pad_r[i].out_val <= (reset_cfg_r == iprl_pkg::RCFG_PULL_UP);
				end else if (state_r == ST_RUN && cfg_we && !low_power) begin
					pad_r[i].drive_mode <= cfg_drive_mode[i*3 +: 3];
					pad_r[i].out_val <= cfg_out_val[i];
				end
			end
		end
	end

	// Interrupt modes and pair configuration
	always_ff @(posedge clk) begin
		if (rst) begin
			imode_r <= '0;
			pair_r <= '0;
		end else if (ce && state_r == ST_RUN && cfg_we && !low_power) begin
			imode_r <= cfg_int_mode;
			pair_r <= cfg_pair;
		end
	end

	// ----------------------------------------------------------------
	// Port interrupt unit
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NPINS; g++) begin : g_edge
			iprl_edge_det u_edge (
				.clk(clk),
				.rst(rst),
				.ce(ce),
				.pin_in(pin_in[g]),
				.mode(imode_r[g*2 +: 2]),
				.event_p(event_p[g])
			);
		end
	endgenerate

	// Sticky status, set wins over clear, runs in low power
	always_ff @(posedge clk) begin
		if (rst) begin
			status_r <= '0;
		end else if (ce) begin
			status_r <= (status_r & ~int_clear) | event_p;
		end
	end

	// ----------------------------------------------------------------
	// Special pin comparator
	// ----------------------------------------------------------------
	// Comparator result per pair; hysteresis is in the pad, result registered
	always_ff @(posedge clk) begin
		if (rst) begin
			cmp_r <= '0;
		end else if (ce) begin
			for (int p = 0; p < NPAIRS; p++) begin
				if (pair_r[p].thr_sel == iprl_pkg::THR_ANALOG_GLOBAL) begin
					cmp_r[p] <= ag_cmp_above[p];
				end else begin
					cmp_r[p] <= pin_in[2*p];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Boundary scan
	// ----------------------------------------------------------------
	// Capture or shift chain through every pin
	always_ff @(posedge clk) begin
		if (rst) begin
			bs_cap_r <= '0;
		end else if (ce) begin
			if (bs_capture) begin
				bs_cap_r <= pin_in;
			end else if (bs_shift) begin
				bs_cap_r <= {bs_tdi, bs_cap_r[NPINS-1:1]};
			end
		end
	end

	// Update stage drives pins in scan mode once the sequencer is in ST_RUN
	always_ff @(posedge clk) begin
		if (rst) begin
			bs_upd_r <= '0;
		end else if (ce && bs_update) begin
			bs_upd_r <= bs_cap_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Scan mode overrides pads with strong drive of update bits once the sequencer is in ST_RUN
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			if (bs_mode && state_r == ST_RUN) begin
				pad[i].drive_mode = iprl_pkg::DM_STRONG;
				pad[i].out_val = bs_upd_r[i];
			end else begin
				pad[i] = pad_r[i];
			end
		end
	end

	assign bs_tdo = bs_cap_r[0];
	assign pair_ref = pair_r;
	assign pair_cmp_out = cmp_r;
	assign int_status = status_r;
	assign int_req = |status_r;
	assign wake_req = low_power & (|status_r);
	assign reset_cfg = reset_cfg_r;
	assign held_in_reset = (state_r != ST_RUN);
endmodule

// [bench/iprl_pin_model.sv]
// External signal source that drives the port pins and the analog comparator result
`timescale 1ns/10ps
module iprl_pin_model #(
	parameter int NPINS = 8
) (
	// Clock
	input wire logic clk,
	// Requested levels
	input wire logic [NPINS-1:0] lvl,
	input wire logic cmp_lvl,
	// Levels seen by the port
	output logic [NPINS-1:0] pin_in,
	output logic [0:0] ag_cmp_above
);
	// Start low, then move outside levels just after each rising edge, never on it
	initial begin
		pin_in = '0;
		ag_cmp_above = '0;
		forever begin
			@(posedge clk);
			pin_in <= #2 lvl;
			ag_cmp_above <= #2 cmp_lvl;
		end
	end
endmodule

// [bench/iprl_port_assertions.sv]
// Checker of pin hold, reset load, retention, pin events, comparator and scan capture
`timescale 1ns/10ps
module iprl_port_chk #(
	parameter int NPINS = 8,
	parameter int NPAIRS = 1
) (
	// Watched ports
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [1:0] nv_reset_cfg,
	input wire logic [NPINS*2-1:0] cfg_int_mode,
	input wire logic low_power,
	input wire logic [NPINS-1:0] pin_in,
	input wire logic [NPAIRS-1:0] ag_cmp_above,
	input wire logic bs_mode,
	input wire logic bs_capture,
	input wire logic bs_tdo,
	input wire iprl_pkg::iprl_pad_t [NPINS-1:0] pad,
	input wire iprl_pkg::iprl_pair_cfg_t [NPAIRS-1:0] pair_ref,
	input wire logic [NPAIRS-1:0] pair_cmp_out,
	input wire logic [NPINS-1:0] int_status,
	input wire logic int_req,
	input wire logic wake_req,
	input wire logic [1:0] reset_cfg,
	input wire logic held_in_reset
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_hold; held_in_reset |-> pad == '0; endproperty
	property p_load; $fell(held_in_reset) |-> reset_cfg == nv_reset_cfg; endproperty
	property p_come_up;
		$fell(held_in_reset) && !bs_mode |-> pad == {NPINS{reset_cfg == 2'h2 ? 4'h5 : (reset_cfg == 2'h1 ? 4'h6 : 4'h0)}};
	endproperty
	property p_retain;
		$past(low_power, 2) && $past(low_power) && !bs_mode && !$past(bs_mode) && !$past(held_in_reset) |-> $stable(pad);
	endproperty
	property p_wake;
		low_power && ce && !held_in_reset && (cfg_int_mode[0] && $rose(pin_in[0]) || cfg_int_mode[1] && $fell(pin_in[0]))
			##1 low_power |-> wake_req && int_req;
	endproperty
	property p_scan_drive; bs_mode && !held_in_reset |-> pad[0].drive_mode == 3'h6; endproperty
	property p_edge;
		!held_in_reset && ce && (cfg_int_mode[0] && $rose(pin_in[0]) || cfg_int_mode[1] && $fell(pin_in[0]))
			|-> ##[1:2] int_status[0];
	endproperty
	property p_cmp;
		!held_in_reset |=> pair_cmp_out[0] == ($past(pair_ref[0].thr_sel) == 2'h3 ? $past(ag_cmp_above[0]) : $past(pin_in[0]));
	endproperty
	property p_scan; ce && bs_capture |=> bs_tdo == $past(pin_in[0]); endproperty
	a_hold: assert property (p_hold) else $error("pad not idle while held");
	a_load: assert property (p_load) else $error("reset config not loaded");
	a_come_up: assert property (p_come_up) else $error("pad wrong after reset");
	a_retain: assert property (p_retain) else $error("pad moved in low power");
	a_wake: assert property (p_wake) else $error("no wake on event");
	a_edge: assert property (p_edge) else $error("pin event missed");
	a_cmp: assert property (p_cmp) else $error("comparator source wrong");
	a_scan: assert property (p_scan) else $error("scan capture wrong");
	a_scan_drive: assert property (p_scan_drive) else $error("scan mode not driving pads");
	// Main scenarios reached
	c_wake: cover property (low_power && wake_req);
	c_run: cover property ($fell(held_in_reset));
	c_ag: cover property (pair_cmp_out[0] && pair_ref[0].thr_sel == 2'h3);
	c_scan: cover property (bs_mode && !held_in_reset);
endmodule
bind iprl_port iprl_port_chk #(.NPINS(NPINS), .NPAIRS(NPAIRS)) u_chk (.*);

// [bench/iprl_port_tb_top.sv]
// Self-checking bench of the port reset and low-power control block
`timescale 1ns/10ps
module iprl_port_tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	typedef struct packed {logic [1:0] m; logic s; logic x;} iprl_row_t;
	// Rows of {mode, start level, event expected}
	iprl_row_t rows [8] = '{4'h0, 4'h2, 4'h5, 4'h6, 4'h8, 4'hb, 4'hd, 4'hf};
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic ce = 1'h1;
	logic [1:0] nv_reset_cfg = iprl_pkg::RCFG_PULL_UP;
	logic cfg_we = 1'h0;
	logic [23:0] cfg_drive_mode = 24'h00_0000;
	logic [7:0] cfg_out_val = 8'h00;
	logic [15:0] cfg_int_mode = 16'h0000;
	iprl_pkg::iprl_pair_cfg_t [0:0] cfg_pair = 3'h0;
	logic low_power = 1'h0;
	logic [7:0] int_clear = 8'h00;
	logic [7:0] lvl = 8'h00;
	logic cmp_lvl = 1'h0;
	logic bs_shift = 1'h0;
	logic bs_capture = 1'h0;
	logic bs_mode = 1'h0;
	logic bs_update = 1'h0;
	logic bs_tdi = 1'h0;
	logic [7:0] pin_in;
	logic [0:0] ag_cmp_above;
	logic bs_tdo;
	iprl_pkg::iprl_pad_t [7:0] pad;
	iprl_pkg::iprl_pair_cfg_t [0:0] pair_ref;
	logic [0:0] pair_cmp_out;
	logic [7:0] int_status;
	logic int_req;
	logic wake_req;
	logic [1:0] reset_cfg;
	logic held_in_reset;
	int fail_count = 0;
	int checked = 0;
	// Clock of 20 ns period
	initial begin
		forever #10 clk = ~clk;
	end
	// Design under test
	iprl_port DUT (.clk(clk), .rst(rst), .ce(ce), .nv_reset_cfg(nv_reset_cfg), .cfg_we(cfg_we),
		.cfg_drive_mode(cfg_drive_mode), .cfg_out_val(cfg_out_val), .cfg_int_mode(cfg_int_mode),
		.cfg_pair(cfg_pair), .low_power(low_power), .int_clear(int_clear), .pin_in(pin_in),
		.ag_cmp_above(ag_cmp_above), .bs_mode(bs_mode), .bs_shift(bs_shift), .bs_capture(bs_capture),
		.bs_update(bs_update), .bs_tdi(bs_tdi), .bs_tdo(bs_tdo), .pad(pad), .pair_ref(pair_ref),
		.pair_cmp_out(pair_cmp_out), .int_status(int_status), .int_req(int_req), .wake_req(wake_req),
		.reset_cfg(reset_cfg), .held_in_reset(held_in_reset));
	iprl_pin_model #(.NPINS(8)) u_ext (.clk(clk), .lvl(lvl), .cmp_lvl(cmp_lvl), .pin_in(pin_in),
		.ag_cmp_above(ag_cmp_above));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] dm, input logic [7:0] ov, input logic [1:0] im, input logic [2:0] pc);
		cfg_drive_mode = {8{dm}};
		cfg_out_val = ov;
		cfg_int_mode = {8{im}};
		cfg_pair = pc;
		cfg_we = 1'h1;
		tick(1);
		cfg_we = 1'h0;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Watchdog well beyond the roughly 125 cycles the tests need
	initial begin
		#100_000;
		fail_count++;
		give_verdict();
	end
	// Main sequence
	initial begin
		tick(12);
		chk("pad_rst", 32'h0, pad);
		rst = 1'h0;
		tick(2);
		chk("held_load", 32'h1, held_in_reset);
		chk("pad_load", 32'h0, pad);
		tick(1);
		chk("reset_cfg", 32'h2, reset_cfg);
		chk("pad_up", 32'h5555_5555, pad);
		foreach (rows[i]) begin
			lvl = {8{rows[i].s}};
			tick(3);
			wr(iprl_pkg::DM_HIZ_DIGITAL, 8'h00, rows[i].m, 3'h0);
			int_clear = 8'hff;
			tick(2);
			int_clear = 8'h00;
			lvl = ~lvl;
			tick(4);
			chk("int_status", rows[i].x ? 32'hff : 32'h0, int_status);
			chk("int_req", rows[i].x, int_req);
		end
		// Retention and wake in low power
		wr(iprl_pkg::DM_STRONG, 8'hff, iprl_pkg::IMODE_BOTH, 3'h0);
		int_clear = 8'hff;
		low_power = 1'h1;
		tick(1);
		int_clear = 8'h00;
		wr(iprl_pkg::DM_OD_LOW, 8'h00, iprl_pkg::IMODE_BOTH, 3'h0);
		tick(1);
		chk("pad_lp", 32'hdddd_dddd, pad);
		lvl = ~lvl;
		tick(4);
		chk("wake_req", 32'h1, wake_req);
		chk("int_status_lp", 32'hff, int_status);
		low_power = 1'h0;
		// Shared pair threshold and comparator source
		lvl = 8'h00;
		cmp_lvl = 1'h1;
		wr(iprl_pkg::DM_HIZ_DIGITAL, 8'h00, iprl_pkg::IMODE_NONE, {iprl_pkg::THR_ANALOG_GLOBAL, 1'h1});
		tick(3);
		chk("pair_ref", 32'h7, pair_ref);
		chk("cmp_ag", 32'h1, pair_cmp_out);
		wr(iprl_pkg::DM_HIZ_DIGITAL, 8'h00, iprl_pkg::IMODE_NONE, {iprl_pkg::THR_HALF_SUPPLY, 1'h1});
		tick(3);
		chk("cmp_pin", 32'h0, pair_cmp_out);
		// Scan capture, one shift with a one entering, update, then scan drive of the pads
		lvl = 8'ha5;
		bs_tdi = 1'h1;
		tick(3);
		bs_capture = 1'h1;
		tick(1);
		bs_capture = 1'h0;
		chk("tdo_cap", 32'h1, bs_tdo);
		bs_shift = 1'h1;
		tick(1);
		bs_shift = 1'h0;
		chk("tdo_shift", 32'h0, bs_tdo);
		bs_update = 1'h1;
		tick(1);
		bs_update = 1'h0;
		bs_mode = 1'h1;
		tick(1);
		chk("pad_scan", 32'hddcd_ccdc, pad);
		bs_mode = 1'h0;
		tick(1);
		chk("pad_func", 32'h2222_2222, pad);
		// Second reset over a live configuration
		rst = 1'h1;
		tick(2);
		chk("pad_rst2", 32'h0, pad);
		nv_reset_cfg = iprl_pkg::RCFG_PULL_DOWN;
		rst = 1'h0;
		tick(3);
		chk("reset_cfg2", 32'h1, reset_cfg);
		chk("pad_down", 32'h6666_6666, pad);
		give_verdict();
	end
endmodule
